// file: verilog/rcrb_pkg.sv
// constants, modes and carriers of the receiver control register bank
// assumes one core clock and an active-low asynchronous reset
// Behaviour
// - byte microport and serial port reach all
// - serial wins unless micro cycle started
// - micro ready low while serial holds bank
// - coefficient memory 256 words of 20 bits
// - tap count comes only from tap register
// - sample word low half I, high Q
// - sample memory reachable, untouched by reset
// - reset sets hold bit, held until cleared
// - only mode register has power-up value
// - reset clears master bit, powers up slave
// - input mode decoded from mode bits 2:1
// - master bit drives sync pins, else inputs
// - bypass gives identical I and Q, minus 12dB
// - phase and amplitude dither independent enables
// - mask write loads shadow, read returns active
// - decimation and tap registers hold value minus one
// - hold accepts no samples, outputs idle, slave
// - sync pulses driven and sampled on rising edge
package rcrb_pkg;
   localparam int ADDR_W  = 10;    // control address width
   localparam int WORD_W  = 36;    // widest bank word
   localparam int STAGE_W = 40;    // five staged micro bytes
   localparam int COEF_W  = 20;    // coefficient width
   localparam int HALF_W  = 18;    // one sample half
   localparam int DEPTH   = 256;   // locations per memory
   localparam int SEL_W   = 3;     // micro byte index width
   localparam int BP_SHIFT = 2;    // 12 dB bypass attenuation
   // address regions on bits 9:8
   localparam logic [1:0] RGN_COEF = 2'h0;
   localparam logic [1:0] RGN_SAMP = 2'h1;
   localparam logic [1:0] RGN_REG  = 2'h3;
   // register offsets
   localparam logic [ADDR_W-1:0] A_MODE  = 10'h300;
   localparam logic [ADDR_W-1:0] A_OSC   = 10'h301;
   localparam logic [ADDR_W-1:0] A_MASK  = 10'h302;
   localparam logic [ADDR_W-1:0] A_TUNE  = 10'h303;
   localparam logic [ADDR_W-1:0] A_PHASE = 10'h304;
   localparam logic [ADDR_W-1:0] A_SC1   = 10'h305;
   localparam logic [ADDR_W-1:0] A_DEC1  = 10'h306;
   localparam logic [ADDR_W-1:0] A_SC2   = 10'h307;
   localparam logic [ADDR_W-1:0] A_DEC2  = 10'h308;
   localparam logic [ADDR_W-1:0] A_OUTSC = 10'h309;
   localparam logic [ADDR_W-1:0] A_DEC3  = 10'h30A;
   localparam logic [ADDR_W-1:0] A_CBASE = 10'h30B;
   localparam logic [ADDR_W-1:0] A_TAPS  = 10'h30C;
   localparam logic [ADDR_W-1:0] A_RSVD  = 10'h30D;
   // mode and oscillator control fields
   localparam int M_HOLD = 0;
   localparam int M_DIV  = 1;
   localparam int M_CPLX = 2;
   localparam int M_MAST = 3;
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam int O_BYP  = 0;
   localparam int O_PDTH = 1;
   localparam int O_ADTH = 2;
   localparam logic [SEL_W-1:0] SEL_COMMIT = 3'h0; // byte 0 ends cycle

   typedef enum logic [1:0] {
      RCRB_SINGLE_REAL = 2'h0,
      RCRB_DIV_REAL    = 2'h1,
      RCRB_CPLX        = 2'h2
   } rcrb_inmode_e;

   // arbiter: idle -> micro or serial -> idle
   typedef enum logic [1:0] {
      RCRB_IDLE = 2'h0,
      RCRB_UP   = 2'h1,
      RCRB_SP   = 2'h2
   } rcrb_arb_e;

   typedef struct packed {
      logic         hold;
      rcrb_inmode_e in_mode;
      logic         master;
      logic         bypass;
      logic         ph_dither;
      logic         amp_dither;
      logic [31:0]  tuning;
      logic [15:0]  phase;
      logic [7:0]   scale1;
      logic [4:0]   scale2;
      logic [2:0]   out_scale;
      logic [7:0]   dec1_m1;
      logic [7:0]   dec2_m1;
      logic [7:0]   dec3_m1;
      logic [7:0]   coef_base;
      logic [7:0]   taps_m1;
   } rcrb_cfg_s;

   typedef struct packed {
      logic [HALF_W-1:0] q;
      logic [HALF_W-1:0] i;
   } rcrb_iq_s;
endpackage : rcrb_pkg

// file: verilog/rcrb_bank.sv
// register bank and on-chip memories behind two control ports
// assumes synchronous port inputs; host holds i_up_req until o_up_rdy
module rcrb_bank
   import rcrb_pkg::*;
#(
   parameter int SAMPLE_W = 16     // input sample width
)(
   input  wire logic              i_core_clk,
   input  wire logic              i_arst_n,
   // microport: one byte per cycle
   input  wire logic              i_up_req,
   input  wire logic              i_up_we,
   input  wire logic [ADDR_W-1:0] i_up_addr,
   input  wire logic [SEL_W-1:0]  i_up_sel,
   input  wire logic [7:0]        i_up_wdata,
   output logic                   o_up_rdy,
   output logic [7:0]             o_up_rdata,
   // serial port, already deserialised to words
   input  wire logic              i_sp_req,
   input  wire logic              i_sp_we,
   input  wire logic [ADDR_W-1:0] i_sp_addr,
   input  wire logic [WORD_W-1:0] i_sp_wdata,
   output logic                   o_sp_ack,
   output logic [WORD_W-1:0]      o_sp_rdata,
   // sync pads and mask transfer event
   input  wire logic              i_integrator_stage_sync_pin_in,
   input  wire logic              i_final_filter_sync_pin_in,
   input  wire logic              i_mask_load,
   output logic                   o_integrator_stage_sync_pin_out,
   output logic                   o_integrator_stage_sync_pin_oe,
   output logic                   o_final_filter_sync_pin_out,
   output logic                   o_final_filter_sync_pin_oe,
   // sample intake for the bypass path
   input  wire logic              i_smp_valid,
   input  wire logic [SAMPLE_W-1:0] i_smp,
   output logic                   o_bp_valid,
   output rcrb_iq_s               o_bp,
   // configuration to the datapath
   output rcrb_cfg_s              o_cfg,
   output logic [31:0]            o_mask_active
);

////////////////////////////////////////////////////////////////////////
// storage
   logic [COEF_W-1:0] coef_mem [DEPTH];  // filter coefficients
   rcrb_iq_s          samp_mem [DEPTH];  // filter sample history
   logic [7:0]        mode;              // mode register
   logic [2:0]        osc;               // oscillator control
   logic [31:0]       mask_shadow;       // written mask copy
   logic [STAGE_W-1:0] stage;            // staged micro bytes
   logic [WORD_W-1:0] up_rbuf;           // fetched word for reads
   rcrb_arb_e         state;             // port arbiter
   rcrb_cfg_s         next_cfg;          // decoded configuration
   logic [7:0]        cnt1;              // first stage phase
   logic [7:0]        cnt2;              // second stage phase
   logic [7:0]        cnt3;              // final stage phase

////////////////////////////////////////////////////////////////////////
// selected access: one port owns the bank for one cycle
   logic              acc_go;            // access commits this edge
   logic              acc_we;            // commit is a write
   logic [ADDR_W-1:0] acc_addr;
   logic [WORD_W-1:0] acc_wdata;
   logic [WORD_W-1:0] acc_rdata;

   // micro writes only reach the bank on the commit byte
   always_comb
   begin
      acc_addr  = (state == RCRB_SP) ? i_sp_addr : i_up_addr;
      acc_wdata = (state == RCRB_SP) ? i_sp_wdata
                  : {stage[WORD_W-1:8], i_up_wdata};
      acc_go = (state == RCRB_SP) ||
               (state == RCRB_UP && i_up_sel == SEL_COMMIT);
      acc_we = (state == RCRB_SP) ? i_sp_we : i_up_we;
   end

   // read decode; unmapped space reads as zero
   always_comb
   begin
      acc_rdata = '0;
      unique case (acc_addr[9:8])
         RGN_COEF: acc_rdata = WORD_W'(coef_mem[acc_addr[7:0]]);
         RGN_SAMP: acc_rdata = samp_mem[acc_addr[7:0]];
         RGN_REG:
         begin
            unique case (acc_addr)
               A_MODE:  acc_rdata = WORD_W'(mode);
               A_OSC:   acc_rdata = WORD_W'(osc);
               A_MASK:  acc_rdata = WORD_W'(o_mask_active);
               A_TUNE:  acc_rdata = WORD_W'(o_cfg.tuning);
               A_PHASE: acc_rdata = WORD_W'(o_cfg.phase);
               A_SC1:   acc_rdata = WORD_W'(o_cfg.scale1);
               A_DEC1:  acc_rdata = WORD_W'(o_cfg.dec1_m1);
               A_SC2:   acc_rdata = WORD_W'(o_cfg.scale2);
               A_DEC2:  acc_rdata = WORD_W'(o_cfg.dec2_m1);
               A_OUTSC: acc_rdata = WORD_W'(o_cfg.out_scale);
               A_DEC3:  acc_rdata = WORD_W'(o_cfg.dec3_m1);
               A_CBASE: acc_rdata = WORD_W'(o_cfg.coef_base);
               A_TAPS:  acc_rdata = WORD_W'(o_cfg.taps_m1);
               default: acc_rdata = '0; // reserved offsets
            endcase
         end
         default: acc_rdata = '0;       // reserved region
      endcase
   end

   logic wr_reg;   // register write strobe
   assign wr_reg = acc_go && acc_we && acc_addr[9:8] == RGN_REG;

////////////////////////////////////////////////////////////////////////
// arbiter: serial first, a started micro cycle always finishes
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         state <= RCRB_IDLE;
      else
         unique case (state)
            RCRB_IDLE:
               if (i_sp_req)
                  state <= RCRB_SP;
               else if (i_up_req)
                  state <= RCRB_UP;
            RCRB_UP: state <= RCRB_IDLE;
            RCRB_SP: state <= RCRB_IDLE;
            default: state <= RCRB_IDLE;       // illegal code
         endcase
   end

   // ready stays low through any serial hold, pulses on completion
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_up_rdy   <= 1'b0;
         o_up_rdata <= 8'h00;
         o_sp_ack   <= 1'b0;
         o_sp_rdata <= '0;
      end
      else
      begin
         o_up_rdy <= (state == RCRB_UP);
         o_sp_ack <= (state == RCRB_SP);
         if (state == RCRB_SP)
            o_sp_rdata <= acc_rdata;
         if (state == RCRB_UP)
            // byte 0 fetches the word, higher bytes read the buffer
            o_up_rdata <= (i_up_sel == SEL_COMMIT) ? acc_rdata[7:0]
                          : 8'((STAGE_W'(up_rbuf)) >> (8 * i_up_sel));
      end
   end

   // micro staging: bytes 1..4 wait here for the commit byte
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         stage   <= '0;
         up_rbuf <= '0;
      end
      else if (state == RCRB_UP)
      begin
         if (i_up_we && i_up_sel != SEL_COMMIT)
            stage[8*i_up_sel +: 8] <= i_up_wdata;
         if (!i_up_we && i_up_sel == SEL_COMMIT)
            up_rbuf <= acc_rdata;
      end
   end

////////////////////////////////////////////////////////////////////////
// memories: no reset, so contents survive a hard reset
   always_ff @(posedge i_core_clk)
   begin
      if (acc_go && acc_we && acc_addr[9:8] == RGN_COEF)
         coef_mem[acc_addr[7:0]] <= acc_wdata[COEF_W-1:0];
      if (acc_go && acc_we && acc_addr[9:8] == RGN_SAMP)
         samp_mem[acc_addr[7:0]] <= acc_wdata;
   end

////////////////////////////////////////////////////////////////////////
// mode register: the only one with a defined power-up value
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         mode <= MODE_RST;
      else if (wr_reg && acc_addr == A_MODE)
         mode <= acc_wdata[7:0];
   end

   // other registers reset to zero only to keep outputs defined
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         osc         <= '0;
         mask_shadow <= '0;
      end
      else
      begin
         if (wr_reg && acc_addr == A_OSC)
            osc <= acc_wdata[2:0];
         if (wr_reg && acc_addr == A_MASK)
            mask_shadow <= acc_wdata[31:0];
      end
   end

   // active mask follows the shadow only on the transfer event
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_mask_active <= '0;
      else if (i_mask_load)
         o_mask_active <= mask_shadow;
   end

////////////////////////////////////////////////////////////////////////
// configuration decode; undefined mode codes fall back to real
   always_comb
   begin
      next_cfg = o_cfg;
      next_cfg.hold = mode[M_HOLD];
      unique case ({mode[M_CPLX], mode[M_DIV]})
         2'h1:    next_cfg.in_mode = RCRB_DIV_REAL;
         2'h2:    next_cfg.in_mode = RCRB_CPLX;
         default: next_cfg.in_mode = RCRB_SINGLE_REAL;
      endcase
      next_cfg.master = mode[M_MAST] & ~mode[M_HOLD];
      next_cfg.bypass     = osc[O_BYP];
      next_cfg.ph_dither  = osc[O_PDTH];
      next_cfg.amp_dither = osc[O_ADTH];
      if (wr_reg)
         unique case (acc_addr)
            A_TUNE:  next_cfg.tuning    = acc_wdata[31:0];
            A_PHASE: next_cfg.phase     = acc_wdata[15:0];
            A_SC1:   next_cfg.scale1    = acc_wdata[7:0];
            A_DEC1:  next_cfg.dec1_m1   = acc_wdata[7:0];
            A_SC2:   next_cfg.scale2    = acc_wdata[4:0];
            A_DEC2:  next_cfg.dec2_m1   = acc_wdata[7:0];
            A_OUTSC: next_cfg.out_scale = acc_wdata[2:0];
            A_DEC3:  next_cfg.dec3_m1   = acc_wdata[7:0];
            A_CBASE: next_cfg.coef_base = acc_wdata[7:0];
            A_TAPS:  next_cfg.taps_m1   = acc_wdata[7:0];
            default: next_cfg.tuning    = o_cfg.tuning;
         endcase
   end

   // mode and oscillator fields lag their register by one edge
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_cfg      <= '0;
         o_cfg.hold <= 1'b1;
      end
      else
         o_cfg <= next_cfg;
   end

////////////////////////////////////////////////////////////////////////
// filter phase counters; an integrator pad pulse realigns cnt1 and cnt2, and cnt3 only with a final pad pulse in the same cycle
   logic wrap1;   // first stage decimation boundary
   logic cic_hit; // both integrator stages wrap
   logic rcf_hit; // final stage wraps too
   assign wrap1   = (cnt1 == o_cfg.dec1_m1);
   assign cic_hit = wrap1 && (cnt2 == o_cfg.dec2_m1);
   assign rcf_hit = cic_hit && (cnt3 == o_cfg.dec3_m1);

   // the master also obeys its own pulse seen back at the pad
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cnt1 <= '0;
         cnt2 <= '0;
         cnt3 <= '0;
      end
      else if (o_cfg.hold || i_integrator_stage_sync_pin_in)
      begin
         cnt1 <= '0;
         cnt2 <= '0;
         cnt3 <= i_final_filter_sync_pin_in ? 8'h00 : cnt3;
      end
      else
      begin
         cnt1 <= wrap1 ? 8'h00 : cnt1 + 8'h01;
         if (wrap1)
            cnt2 <= cic_hit ? 8'h00 : cnt2 + 8'h01;
         if (cic_hit)
            cnt3 <= rcf_hit ? 8'h00 : cnt3 + 8'h01;
      end
   end

   // pads driven only by an active master
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_integrator_stage_sync_pin_oe  <= 1'b0;
         o_final_filter_sync_pin_oe  <= 1'b0;
         o_integrator_stage_sync_pin_out <= 1'b0;
         o_final_filter_sync_pin_out <= 1'b0;
      end
      else
      begin
         o_integrator_stage_sync_pin_oe  <= o_cfg.master;
         o_final_filter_sync_pin_oe  <= o_cfg.master;
         o_integrator_stage_sync_pin_out <= o_cfg.master && cic_hit;
         o_final_filter_sync_pin_out <= o_cfg.master && rcf_hit;
      end
   end

////////////////////////////////////////////////////////////////////////
// bypass path: untranslated sample on both halves, down 12 dB
   logic [HALF_W-1:0] bp_word;
   assign bp_word = HALF_W'($signed({i_smp, 2'b00}) >>> BP_SHIFT);

   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_bp_valid <= 1'b0;
         o_bp       <= '0;
      end
      else
      begin
         // hold refuses samples outright
         o_bp_valid <= i_smp_valid && o_cfg.bypass && !o_cfg.hold;
         if (i_smp_valid && o_cfg.bypass && !o_cfg.hold)
            o_bp <= '{q: bp_word, i: bp_word};
      end
   end

////////////////////////////////////////////////////////////////////////
// checks
   sequence sp_grant;
      state == RCRB_IDLE && i_sp_req ##1 state == RCRB_SP;
   endsequence
   sequence up_start;
      state == RCRB_IDLE && !i_sp_req && i_up_req;
   endsequence

   chk_sp_first: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) state == RCRB_IDLE && i_sp_req |-> sp_grant)
      else $error("serial request lost arbitration");
   chk_up_done: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) up_start |=> ##1 o_up_rdy)
      else $error("started micro cycle did not finish");
   chk_rdy_hold: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) sp_grant |=> !o_up_rdy && o_sp_ack)
      else $error("ready high during serial hold");
   chk_hold_stay: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) mode[M_HOLD] && !wr_reg |=> mode[M_HOLD])
      else $error("hold left without a write");
   chk_slave_oe: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) o_integrator_stage_sync_pin_oe |-> $past(mode[M_MAST], 2)
                              && !$past(mode[M_HOLD], 2))
      else $error("sync pad driven while not master");
   chk_mode_fall: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) mode[M_DIV] && mode[M_CPLX]
                              |=> o_cfg.in_mode == RCRB_SINGLE_REAL)
      else $error("undefined mode not real");
   chk_taps_write: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) wr_reg && acc_addr == A_TAPS
                              |=> o_cfg.taps_m1 == $past(acc_wdata[7:0]))
      else $error("tap register write missed");
   chk_mask_read: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) state == RCRB_SP && i_sp_addr == A_MASK
      |=> o_sp_rdata == WORD_W'($past(o_mask_active)))
      else $error("mask read not the active copy");
   chk_bypass_iq: assert property (@(posedge i_core_clk)
      disable iff (!i_arst_n) o_bp_valid |-> o_bp.i == o_bp.q
                              && $past(o_cfg.bypass))
      else $error("bypass halves differ");
endmodule : rcrb_bank

// file: testbench/rcrb_sp_host.sv
// serial control master model for the register bank bench
// assumes the bank answers each word with a one-cycle ack pulse
module rcrb_sp_host
   import rcrb_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_ack,
   input  wire logic [WORD_W-1:0] i_rdata,
   output logic                   o_req,
   output logic                   o_we,
   output logic [ADDR_W-1:0]      o_addr,
   output logic [WORD_W-1:0]      o_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      o_req = 1'b0;
      o_we = 1'b0;
      o_addr = '0;
      o_wdata = '0;
   end
   // one word access; gap idles first so the model can be slow
   task access(input logic we, input logic [ADDR_W-1:0] a,
               input logic [WORD_W-1:0] d, input int gap,
               output logic [WORD_W-1:0] q, output logic ok);
      int n;
      repeat (gap + 1) @(negedge i_core_clk);
      o_req = 1'b1;
      o_we = we;
      o_addr = a;
      o_wdata = d;
      ok = 1'b0;
      // request held until ack is seen, dropped in the ack cycle
      for (n = 0; n < 20 && !ok; n++)
      begin
         @(negedge i_core_clk);
         ok = (i_ack === 1'b1);
      end
      q = i_rdata;
      o_req = 1'b0;
      // released lines must not keep the old value
      o_addr = ~a;
      o_wdata = ~d;
   endtask : access
endmodule : rcrb_sp_host

// file: testbench/test_receiver_control_register_bank.sv
// bench for the receiver control register bank
// assumes the serial side is driven by rcrb_sp_host
module test_receiver_control_register_bank
   import rcrb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, up_req, up_we, smp_v, mload, up_rdy, bp_v;
   logic sp_req, sp_we, sp_ack, cic_o, cic_oe, rcf_o, rcf_oe;
   logic [ADDR_W-1:0] up_addr, sp_addr;
   logic [SEL_W-1:0]  up_sel;
   logic [7:0]        up_wd, up_rd;
   logic [15:0]       smp;
   logic [WORD_W-1:0] sp_wd, sp_rd;
   logic [31:0]       mact;
   rcrb_iq_s          bp;
   rcrb_cfg_s         cfg;
   int                fails, checks;
   rcrb_bank rcrb_bank_inst (.i_core_clk(clk), .i_arst_n(rst_n),
      .i_up_req(up_req), .i_up_we(up_we), .i_up_addr(up_addr),
      .i_up_sel(up_sel), .i_up_wdata(up_wd), .o_up_rdy(up_rdy),
      .o_up_rdata(up_rd), .i_sp_req(sp_req), .i_sp_we(sp_we),
      .i_sp_addr(sp_addr), .i_sp_wdata(sp_wd), .o_sp_ack(sp_ack),
      .o_sp_rdata(sp_rd), .i_integrator_stage_sync_pin_in(cic_o & cic_oe),
      .i_final_filter_sync_pin_in(rcf_o & rcf_oe), .i_mask_load(mload),
      .o_integrator_stage_sync_pin_out(cic_o),
      .o_integrator_stage_sync_pin_oe(cic_oe), .o_final_filter_sync_pin_out(rcf_o),
      .o_final_filter_sync_pin_oe(rcf_oe), .i_smp_valid(smp_v), .i_smp(smp),
      .o_bp_valid(bp_v), .o_bp(bp), .o_cfg(cfg), .o_mask_active(mact));
   rcrb_sp_host rcrb_sp_host_inst (.i_core_clk(clk), .i_ack(sp_ack),
      .i_rdata(sp_rd), .o_req(sp_req), .o_we(sp_we), .o_addr(sp_addr),
      .o_wdata(sp_wd));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////
   task results;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   task chk(input logic [39:0] seen, input logic [39:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one micro byte cycle; req held until ready is seen
   task up_cyc(input logic we, input logic [ADDR_W-1:0] a,
               input logic [SEL_W-1:0] s, input logic [7:0] d,
               output logic [7:0] q);
      int n;
      logic ok;
      @(negedge clk);
      up_req = 1'b1;
      up_we = we;
      up_addr = a;
      up_sel = s;
      up_wd = d;
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++)
      begin
         @(negedge clk);
         ok = (up_rdy === 1'b1);
      end
      q = up_rd;
      up_req = 1'b0;
      up_wd = ~d;
      if (!ok)
      begin
         fails++;
         results;
      end
   endtask : up_cyc
   // staged bytes 4..1 first, byte 0 commits the word
   task up_wr(input logic [ADDR_W-1:0] a, input logic [39:0] w);
      logic [7:0] b;
      for (int s = 4; s >= 0; s--)
         up_cyc(1'b1, a, s[SEL_W-1:0], w[8*s+:8], b);
   endtask : up_wr
   task up_rd_w(input logic [ADDR_W-1:0] a, output logic [39:0] w);
      for (int s = 0; s <= 4; s++)
         up_cyc(1'b0, a, s[SEL_W-1:0], 8'h00, w[8*s+:8]);
   endtask : up_rd_w
   task sp(input logic we, input logic [ADDR_W-1:0] a,
           input logic [WORD_W-1:0] d, output logic [WORD_W-1:0] q);
      logic ok;
      rcrb_sp_host_inst.access(we, a, d, 0, q, ok);
      if (!ok)
      begin
         fails++;
         results;
      end
   endtask : sp
   ////////////////////////////////////////////////////////////////////
   task t_reset;
      logic [39:0] w;
      up_rd_w(A_MODE, w);
      chk(w, 40'h01);
      chk({cfg.hold, cfg.master, cic_oe, rcf_oe}, 40'h8);
      chk(cfg.taps_m1, 40'h00);
      $display("reset done");
   endtask : t_reset
   task t_mem;
      logic [39:0] w;
      logic [WORD_W-1:0] q;
      up_wr(10'h0FF, 40'hFF_FFF8_1234);
      sp(1'b0, 10'h0FF, '0, q);
      chk(q, 40'h8_1234);
      sp(1'b1, 10'h1FF, 36'hA_AAA9_5555, q);
      up_rd_w(10'h1FF, w);
      chk(w[17:0], 40'h1_5555);
      chk(w[35:18], 40'h2_AAAA);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      up_rd_w(10'h1FF, w);
      chk(w, 40'hA_AAA9_5555);
      $display("memories done");
   endtask : t_mem
   task t_mode;
      logic [WORD_W-1:0] q;
      logic [7:0] m [4] = '{8'h00, 8'h02, 8'h04, 8'h06};
      logic [1:0] e [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
      for (int i = 0; i < 4; i++)
      begin
         up_wr(A_MODE, {32'h0, m[i]});
         repeat (2) @(negedge clk);
         chk({cfg.hold, cfg.in_mode}, {38'h0, e[i]});
         sp(1'b0, A_MODE, '0, q);
         chk(q, m[i]);
      end
      sp(1'b1, A_MODE, 36'h08, q);
      repeat (3) @(negedge clk);
      chk({cfg.master, cic_oe, rcf_oe}, 40'h7);
      chk({cic_o, rcf_o}, 40'h3);
      // bypass on, so only hold can keep the samples out
      sp(1'b1, A_OSC, 36'h1, q);
      sp(1'b1, A_MODE, 36'h09, q);
      repeat (3) @(negedge clk);
      chk({cfg.hold, cfg.master, cic_oe, rcf_oe, cic_o}, 40'h10);
      smp_v = 1'b1;
      smp = 16'h1234;
      repeat (4)
      begin
         @(negedge clk);
         chk(bp_v, 40'h0);
      end
      smp_v = 1'b0;
      $display("mode done");
   endtask : t_mode
   task t_osc;
      logic [WORD_W-1:0] q;
      int n;
      sp(1'b1, A_MODE, 36'h00, q);
      // ends with bypass on for the sample below
      for (int v = 0; v < 8; v++)
      begin
         sp(1'b1, A_OSC, v, q);
         repeat (2) @(negedge clk);
         chk({cfg.amp_dither, cfg.ph_dither, cfg.bypass}, v);
      end
      smp_v = 1'b1;
      @(negedge clk);
      smp_v = 1'b0;
      for (n = 0; n < 10 && bp_v !== 1'b1; n++)
         @(negedge clk);
      if (bp_v !== 1'b1)
      begin
         fails++;
         results;
      end
      chk({bp_v, bp}, {1'b1, 18'h0_1234, 18'h0_1234});
      $display("oscillator done");
   endtask : t_osc
   task t_mask;
      logic [WORD_W-1:0] q;
      sp(1'b1, A_MASK, 36'hA5A5_0F0F, q);
      sp(1'b0, A_MASK, '0, q);
      chk(q, 40'h0);
      chk(mact, 40'h0);
      mload = 1'b1;
      @(negedge clk);
      mload = 1'b0;
      @(negedge clk);
      sp(1'b0, A_MASK, '0, q);
      chk(q, 40'hA5A5_0F0F);
      chk(mact, 40'hA5A5_0F0F);
      $display("mask done");
   endtask : t_mask
   task t_regs;
      logic [WORD_W-1:0] q;
      logic [ADDR_W-1:0] a [9] = '{A_TUNE, A_PHASE, A_SC1, A_DEC1, A_SC2,
                                   A_DEC2, A_DEC3, A_CBASE, A_TAPS};
      int wd [9] = '{32, 16, 8, 8, 5, 8, 8, 8, 8};
      for (int i = 0; i < 9; i++)
      begin
         sp(1'b1, a[i], '1, q);
         sp(1'b0, a[i], '0, q);
         chk(q, (40'h1 << wd[i]) - 40'h1);
      end
      sp(1'b1, A_TAPS, 36'hF_FFFF_FF7F, q);
      chk(cfg.taps_m1, 40'h7F);
      sp(1'b1, A_RSVD, '1, q);
      sp(1'b0, A_RSVD, '0, q);
      chk(q, 40'h0);
      sp(1'b0, 10'h200, '0, q);
      chk(q, 40'h0);
      $display("registers done");
   endtask : t_regs
   task t_arb;
      logic [WORD_W-1:0] q;
      logic [7:0] b;
      logic ok;
      time ts, tu;
      fork
         begin
            up_cyc(1'b1, A_SC1, SEL_COMMIT, 8'h5A, b);
            tu = $time;
         end
         begin
            rcrb_sp_host_inst.access(1'b1, A_DEC1, 36'h33, 0, q, ok);
            ts = $time;
         end
      join
      chk({ok, ts < tu}, 40'h3);
      if (!ok)
         results;
      fork
         begin
            up_cyc(1'b1, A_SC1, SEL_COMMIT, 8'h66, b);
            tu = $time;
         end
         begin
            rcrb_sp_host_inst.access(1'b1, A_DEC1, 36'h44, 1, q, ok);
            ts = $time;
         end
      join
      chk({ok, tu < ts}, 40'h3);
      if (!ok)
         results;
      chk({cfg.scale1, cfg.dec1_m1}, 40'h6644);
      $display("arbitration done");
   endtask : t_arb
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      fails = 0;
      checks = 0;
      rst_n = 1'b0;
      {up_req, up_we, smp_v, mload} = 4'h0;
      up_addr = '0;
      up_sel = '0;
      up_wd = '0;
      smp = '0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_reset;
      t_mem;
      t_mode;
      t_osc;
      t_mask;
      t_regs;
      t_arb;
      results;
   end
endmodule : test_receiver_control_register_bank
